// ===== shared/prc_pkg.sv
// Purpose: constants for the paged register file with clock configuration
// Assumes: 8-bit registers, 128 addresses per page, byte-wide host port
// Notes:   coefficient pages map onto one internal byte store
package prc_pkg;

  localparam int unsigned REG_W       = 8;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned PAGE_REGS   = 128;
  localparam int unsigned SLOT_W      = 5;
  localparam int unsigned SLOT_COUNT  = 20;
  localparam int unsigned MEM_DEPTH   = SLOT_COUNT * PAGE_REGS;
  localparam int unsigned MEM_IDX_W   = SLOT_W + ADDR_W;

  // page 0 offsets
  localparam logic [6:0] OFS_PAGE_SEL   = 7'h00;
  localparam logic [6:0] OFS_SOFT_RST   = 7'h01;
  localparam logic [6:0] OFS_RSVD_RO    = 7'h02;
  localparam logic [6:0] OFS_RSVD_THREE = 7'h03;
  localparam logic [6:0] OFS_CLK_SRC    = 7'h04;
  localparam logic [6:0] OFS_PLL_PR     = 7'h05;
  localparam logic [6:0] OFS_PLL_J      = 7'h06;

  // field positions
  localparam int unsigned SRST_BIT      = 0;
  localparam int unsigned RANGE_BIT     = 6;
  localparam int unsigned REF_LSB       = 2;
  localparam int unsigned SRC_LSB       = 0;
  localparam int unsigned PWR_BIT       = 7;
  localparam int unsigned P_LSB         = 4;
  localparam int unsigned R_LSB         = 0;
  localparam int unsigned J_LSB         = 0;

  // values after reset
  localparam logic [7:0] RST_PAGE       = 8'h00;
  localparam logic [7:0] RST_RSVD_THREE = 8'h00;
  localparam logic       RST_RANGE      = 1'b0;
  localparam logic [1:0] RST_REF        = 2'h0;
  localparam logic [1:0] RST_SRC        = 2'h0;
  localparam logic       RST_PWR        = 1'b0;
  localparam logic [2:0] RST_P          = 3'h1;
  localparam logic [3:0] RST_R          = 4'h1;
  localparam logic [5:0] RST_J          = 6'h04;

  // legal code limits
  localparam logic [3:0] R_MIN          = 4'h1;
  localparam logic [3:0] R_MAX          = 4'h4;
  localparam logic [5:0] J_MIN          = 6'h04;

  // coefficient pages and biquad layout
  localparam logic [7:0] PG_HOME        = 8'h00;
  localparam logic [7:0] PG_CTRL        = 8'h01;
  localparam logic [7:0] PG_COEF_A_LO   = 8'h2c;
  localparam logic [7:0] PG_COEF_A_HI   = 8'h34;
  localparam logic [7:0] PG_COEF_B_LO   = 8'h3e;
  localparam logic [7:0] PG_COEF_B_HI   = 8'h46;
  localparam logic [7:0] PG_BQF_D2      = 8'h2d;
  localparam logic [6:0] BQF_D2_BASE    = 7'h08;
  localparam int unsigned BQ_FIRST      = 12;
  localparam int unsigned BQ_STRIDE     = 20;
  localparam int unsigned TERM_STRIDE   = 4;
  localparam int unsigned COEF_BYTES    = 3;
  localparam int unsigned BQ_SIXTH      = 5;
  localparam int unsigned TERM_D1       = 3;

  // base address of a biquad term: terms N0,N1,N2,D1,D2 in order
  function automatic logic [6:0] bq_coef_addr(input int unsigned bq, input int unsigned term);
    bq_coef_addr = 7'(BQ_FIRST + BQ_STRIDE * bq + TERM_STRIDE * term);
  endfunction

endpackage

// ===== hw/prc_regfile.sv
// Purpose: paged control register file with clock source and pll settings
// Assumes: host protocol engine on the same clock delivers bytes as strobes
// Notes:   start loads the register address; each byte advances it by one
//
// Functional notes
// - every register is eight bits, bit 7 most significant
// - register space is paged, 128 addresses per page
// - hardware reset selects page zero
// - address zero of any page selects the active page, 0 to 255
// - writable registers read back; status registers are read only
// - writing one to soft reset bit resets the device, bit self clears; here only page, register 3, clock mux and pll fields reset, not coefficients
// - page zero register two is read only, pattern 0xxx 0xxx
// - clock mux bit 6 selects low or high pll range, resets zero
// - clock mux bits 3-2 choose pll reference pin
// - clock mux bits 1-0 choose converter clock source, resets 00
// - pll register bit 7 powers the pll, resets zero
// - pll bits 6-4 set divider p, 000 means eight, resets 001
// - pll bits 3-0 set multiplier r, codes 1 to 4 legal
// - coefficients take three bytes, biquad terms four addresses apart, biquads twenty
// - sixth biquad d2 lives at page 45 registers 8 to 10
// - pll j field uses codes 4 to 63 directly
`timescale 1ns/1ps
module prc_regfile (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        host_start_i,
  input  wire logic [6:0]  host_addr_i,
  input  wire logic        host_wr_i,
  input  wire logic [7:0]  host_wdata_i,
  input  wire logic        host_rd_i,
  input  wire logic [5:0]  device_status_i,
  output logic      [7:0]  host_rdata_o,
  output logic             host_rvalid_o,
  output logic      [7:0]  active_page_o,
  output logic             soft_reset_o,
  output logic             pll_range_o,
  output logic      [1:0]  pll_ref_sel_o,
  output logic      [1:0]  converter_clock_source_o,
  output logic             pll_power_o,
  output logic      [3:0]  pll_p_div_o,
  output logic      [3:0]  pll_r_mult_o,
  output logic             pll_r_valid_o,
  output logic      [5:0]  pll_j_o,
  output logic             pll_j_valid_o,
  output logic      [23:0] sixth_biquad_d1_o,
  output logic      [23:0] sixth_biquad_d2_o
);

  typedef struct packed {
    logic [7:0]  page;
    logic [6:0]  addr;
    logic [7:0]  rsvd_three;
    logic        pll_range;
    logic [1:0]  pll_ref;
    logic [1:0]  conv_src;
    logic        pll_pwr;
    logic [2:0]  p_code;
    logic [3:0]  r_code;
    logic [5:0]  j_code;
    logic [23:0] bqf_d1;
    logic [23:0] bqf_d2;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        srst;
  } prc_state_t;

  prc_state_t   st_reg;
  prc_state_t   st_next;
  logic [7:0]   coef_mem [prc_pkg::MEM_DEPTH];

  logic [6:0]   cur_addr;
  logic         page_ok;
  logic [4:0]   slot;
  logic [11:0]  mem_idx;
  logic         home;
  logic [7:0]   rd_val;
  logic         mem_we;
  logic [6:0]   d1_base;

  // map an available page to its storage slot
  always_comb begin
    page_ok = 1'b1;
    slot    = 5'h00;
    if (st_reg.page == prc_pkg::PG_HOME) begin
      slot = 5'h00;
    end else if (st_reg.page == prc_pkg::PG_CTRL) begin
      slot = 5'h01;
    end else if (st_reg.page >= prc_pkg::PG_COEF_A_LO && st_reg.page <= prc_pkg::PG_COEF_A_HI) begin
      slot = 5'(st_reg.page - prc_pkg::PG_COEF_A_LO + 8'h02);
    end else if (st_reg.page >= prc_pkg::PG_COEF_B_LO && st_reg.page <= prc_pkg::PG_COEF_B_HI) begin
      slot = 5'(st_reg.page - prc_pkg::PG_COEF_B_LO + 8'h0b);
    end else begin
      page_ok = 1'b0;
    end
  end

  assign cur_addr = host_start_i ? host_addr_i : st_reg.addr;
  assign mem_idx  = {slot, cur_addr};
  assign home     = st_reg.page == prc_pkg::PG_HOME;
  assign d1_base  = prc_pkg::bq_coef_addr(prc_pkg::BQ_SIXTH, prc_pkg::TERM_D1);
  assign mem_we   = host_wr_i && page_ok && cur_addr != prc_pkg::OFS_PAGE_SEL
                    && !(home && cur_addr <= prc_pkg::OFS_PLL_J);

  always_comb begin
    rd_val = 8'h00;
    if (cur_addr == prc_pkg::OFS_PAGE_SEL) begin
      rd_val = st_reg.page;
    end else if (!page_ok) begin
      rd_val = 8'h00;
    end else if (home && cur_addr <= prc_pkg::OFS_PLL_J) begin
      case (cur_addr)
        prc_pkg::OFS_SOFT_RST:   rd_val = 8'h00;
        // read-only status with zero bits 7 and 3
        prc_pkg::OFS_RSVD_RO:    rd_val = {1'b0, device_status_i[5:3], 1'b0, device_status_i[2:0]};
        prc_pkg::OFS_RSVD_THREE: rd_val = st_reg.rsvd_three;
        prc_pkg::OFS_CLK_SRC:    rd_val = {1'b0, st_reg.pll_range, 2'b00, st_reg.pll_ref,
                                           st_reg.conv_src};
        prc_pkg::OFS_PLL_PR:     rd_val = {st_reg.pll_pwr, st_reg.p_code, st_reg.r_code};
        prc_pkg::OFS_PLL_J:      rd_val = {2'b00, st_reg.j_code};
        default:                 rd_val = 8'h00;
      endcase
    end else begin
      rd_val = coef_mem[mem_idx];
    end
  end

  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = host_rd_i;
    st_next.srst   = 1'b0;
    if (host_rd_i) begin
      st_next.rdata = rd_val;
    end
    if (host_start_i) begin
      st_next.addr = host_addr_i;
    end
    if (host_wr_i || host_rd_i) begin
      // one step per byte, wraps within the page
      st_next.addr = cur_addr + 7'h01;
    end
    if (host_wr_i) begin
      if (cur_addr == prc_pkg::OFS_PAGE_SEL) begin
        st_next.page = host_wdata_i;
      end else if (page_ok && home) begin
        case (cur_addr)
          prc_pkg::OFS_SOFT_RST: begin
            st_next.srst = host_wdata_i[prc_pkg::SRST_BIT];
          end
          prc_pkg::OFS_RSVD_THREE: st_next.rsvd_three = host_wdata_i;
          prc_pkg::OFS_CLK_SRC: begin
            st_next.pll_range = host_wdata_i[prc_pkg::RANGE_BIT];
            st_next.pll_ref   = host_wdata_i[prc_pkg::REF_LSB +: 2];
            st_next.conv_src  = host_wdata_i[prc_pkg::SRC_LSB +: 2];
          end
          prc_pkg::OFS_PLL_PR: begin
            st_next.pll_pwr = host_wdata_i[prc_pkg::PWR_BIT];
            st_next.p_code  = host_wdata_i[prc_pkg::P_LSB +: 3];
            st_next.r_code  = host_wdata_i[prc_pkg::R_LSB +: 4];
          end
          prc_pkg::OFS_PLL_J: st_next.j_code = host_wdata_i[prc_pkg::J_LSB +: 6];
          default: st_next.rsvd_three = st_reg.rsvd_three;
        endcase
      end
      // shadow of sixth biquad d1, msb first
      if (st_reg.page == prc_pkg::PG_COEF_A_LO && cur_addr >= d1_base
          && cur_addr < d1_base + 7'(prc_pkg::COEF_BYTES)) begin
        st_next.bqf_d1[8 * (2 - int'(cur_addr - d1_base)) +: 8] = host_wdata_i;
      end
      // sixth biquad d2 on the next page
      if (st_reg.page == prc_pkg::PG_BQF_D2 && cur_addr >= prc_pkg::BQF_D2_BASE
          && cur_addr < prc_pkg::BQF_D2_BASE + 7'(prc_pkg::COEF_BYTES)) begin
        st_next.bqf_d2[8 * (2 - int'(cur_addr - prc_pkg::BQF_D2_BASE)) +: 8] = host_wdata_i;
      end
    end
    // soft reset returns control state to reset values
    if (st_next.srst) begin
      st_next.page       = prc_pkg::RST_PAGE;
      st_next.rsvd_three = prc_pkg::RST_RSVD_THREE;
      st_next.pll_range  = prc_pkg::RST_RANGE;
      st_next.pll_ref    = prc_pkg::RST_REF;
      st_next.conv_src   = prc_pkg::RST_SRC;
      st_next.pll_pwr    = prc_pkg::RST_PWR;
      st_next.p_code     = prc_pkg::RST_P;
      st_next.r_code     = prc_pkg::RST_R;
      st_next.j_code     = prc_pkg::RST_J;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_reg            <= '0;
      st_reg.page       <= prc_pkg::RST_PAGE;
      st_reg.rsvd_three <= prc_pkg::RST_RSVD_THREE;
      st_reg.pll_range  <= prc_pkg::RST_RANGE;
      st_reg.pll_ref    <= prc_pkg::RST_REF;
      st_reg.conv_src   <= prc_pkg::RST_SRC;
      st_reg.pll_pwr    <= prc_pkg::RST_PWR;
      st_reg.p_code     <= prc_pkg::RST_P;
      st_reg.r_code     <= prc_pkg::RST_R;
      st_reg.j_code     <= prc_pkg::RST_J;
    end else begin
      st_reg <= st_next;
    end
  end

  // coefficient and generic byte store
  always_ff @(posedge sys_clk_i) begin
    if (mem_we) begin
      coef_mem[mem_idx] <= host_wdata_i;
    end
  end

  assign host_rdata_o             = st_reg.rdata;
  assign host_rvalid_o            = st_reg.rvalid;
  assign active_page_o            = st_reg.page;
  assign soft_reset_o             = st_reg.srst;
  assign pll_range_o              = st_reg.pll_range;
  assign pll_ref_sel_o            = st_reg.pll_ref;
  assign converter_clock_source_o = st_reg.conv_src;
  assign pll_power_o              = st_reg.pll_pwr;
  assign pll_p_div_o              = (st_reg.p_code == 3'h0) ? 4'h8 : {1'b0, st_reg.p_code};
  assign pll_r_mult_o             = st_reg.r_code;
  assign pll_r_valid_o            = st_reg.r_code >= prc_pkg::R_MIN && st_reg.r_code <= prc_pkg::R_MAX;
  assign pll_j_o                  = st_reg.j_code;
  assign pll_j_valid_o            = st_reg.j_code >= prc_pkg::J_MIN;
  assign sixth_biquad_d1_o        = st_reg.bqf_d1;
  assign sixth_biquad_d2_o        = st_reg.bqf_d2;

  // checks
  logic wr0;
  logic rd0;
  assign wr0 = host_wr_i && home;
  assign rd0 = host_rd_i && home;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_page_reset;
    $past(!reset_n_i) |-> active_page_o == 8'h00 && !pll_power_o;
  endproperty
  a_page_reset: assert property (p_page_reset) else $error("page not zero after reset");

  property p_page_select;
    host_wr_i && cur_addr == 7'h00 |=> active_page_o == $past(host_wdata_i);
  endproperty
  a_page_select: assert property (p_page_select) else $error("page select not taken");

  property p_clk_readback;
    rd0 && cur_addr == 7'h04 |=> host_rvalid_o
      && host_rdata_o == {1'b0, pll_range_o, 2'b00, pll_ref_sel_o, converter_clock_source_o};
  endproperty
  a_clk_readback: assert property (p_clk_readback) else $error("clock mux readback wrong");

  property p_soft_reset;
    wr0 && cur_addr == 7'h01 && host_wdata_i[0]
      |=> soft_reset_o && active_page_o == 8'h00 && pll_p_div_o == 4'h1 ##1 !soft_reset_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset misbehaves");

  property p_ro_two;
    rd0 && cur_addr == 7'h02 |=> host_rdata_o[7] == 1'b0 && host_rdata_o[3] == 1'b0;
  endproperty
  a_ro_two: assert property (p_ro_two) else $error("register two pattern wrong");

  property p_ref_write;
    wr0 && cur_addr == 7'h04 |=> pll_ref_sel_o == $past(host_wdata_i[3:2])
      && pll_range_o == $past(host_wdata_i[6]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("pll reference not updated");

  property p_p_div;
    wr0 && cur_addr == 7'h05 && host_wdata_i[6:4] == 3'h0 |=> pll_p_div_o == 4'h8;
  endproperty
  a_p_div: assert property (p_p_div) else $error("divider code zero not eight");

  property p_r_reserved;
    wr0 && cur_addr == 7'h05 && host_wdata_i[3:0] == 4'h0 |=> !pll_r_valid_o;
  endproperty
  a_r_reserved: assert property (p_r_reserved) else $error("reserved r flagged valid");

  property p_incr;
    (host_wr_i || host_rd_i) ##1 (host_wr_i && !host_start_i)
      |-> cur_addr == 7'($past(cur_addr) + 7'h01);
  endproperty
  a_incr: assert property (p_incr) else $error("address did not advance");

  property p_bqf_d2;
    host_wr_i && st_reg.page == 8'h2d && cur_addr == 7'h0a
      |=> sixth_biquad_d2_o[7:0] == $past(host_wdata_i);
  endproperty
  a_bqf_d2: assert property (p_bqf_d2) else $error("sixth biquad d2 low byte wrong");

  property p_j_write;
    wr0 && cur_addr == 7'h06 |=> pll_j_o == $past(host_wdata_i[5:0]);
  endproperty
  a_j_write: assert property (p_j_write) else $error("pll j not stored");

  c_page_coef: cover property (host_wr_i && cur_addr == 7'h00 && host_wdata_i == 8'h2c);
  c_soft_reset: cover property (soft_reset_o);
  c_bqf_d2: cover property (host_wr_i && st_reg.page == 8'h2d && cur_addr == 7'h08
                            ##1 host_wr_i ##1 host_wr_i);
  c_clk_read: cover property (rd0 && cur_addr == 7'h04);

endmodule // prc_regfile

// ===== sim/prc_host_model.sv
// Purpose: host side of the byte port, one transfer per strobe
// Assumes: strobes change 1 ns after the rising edge and hold to the next
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module prc_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] host_rdata_i,
  input  wire logic       host_rvalid_i,
  output logic            host_start_o,
  output logic      [6:0] host_addr_o,
  output logic            host_wr_o,
  output logic      [7:0] host_wdata_o,
  output logic            host_rd_o
);
  initial begin
    {host_start_o, host_addr_o, host_wr_o, host_wdata_o, host_rd_o} = '0;
  end
  task automatic step(input logic s, input logic [6:0] a, input logic w,
                      input logic [7:0] d, input logic r);
    {host_start_o, host_addr_o, host_wr_o, host_wdata_o, host_rd_o} = {s, a, w, d, r};
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic idle();
    {host_start_o, host_addr_o, host_wr_o, host_wdata_o, host_rd_o} =
      {1'b0, ~host_addr_o, 1'b0, ~host_wdata_o, 1'b0};
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    step(1'b1, a, 1'b1, d, 1'b0);
    idle();
  endtask
  task automatic wr3(input logic [6:0] a, input logic [23:0] v);
    step(1'b1, a, 1'b1, v[23:16], 1'b0);
    step(1'b0, ~a, 1'b1, v[15:8], 1'b0);
    step(1'b0, ~a, 1'b1, v[7:0], 1'b0);
    idle();
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] q, output logic v);
    step(1'b1, a, 1'b0, 8'h00, 1'b1);
    q = host_rdata_i;
    v = host_rvalid_i;
    idle();
  endtask
  task automatic rd3(input logic [6:0] a, output logic [23:0] q, output logic v);
    step(1'b1, a, 1'b0, 8'h00, 1'b1);
    q[23:16] = host_rdata_i;
    v = host_rvalid_i;
    step(1'b0, ~a, 1'b0, 8'h00, 1'b1);
    q[15:8] = host_rdata_i;
    v = v & host_rvalid_i;
    step(1'b0, ~a, 1'b0, 8'h00, 1'b1);
    q[7:0] = host_rdata_i;
    v = v & host_rvalid_i;
    idle();
  endtask
endmodule // prc_host_model

// ===== sim/tb.sv
// Purpose: self-checking bench for the paged register file
// Assumes: host model drives the byte port, status input held fixed
// Notes:   one task per scenario, expectations from field codes
`timescale 1ns/1ps
module tb;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [5:0]  device_status_i = 6'h2d;
  logic        host_start_i, host_wr_i, host_rd_i;
  logic [6:0]  host_addr_i;
  logic [7:0]  host_wdata_i, host_rdata_o, active_page_o;
  logic        host_rvalid_o, soft_reset_o, pll_range_o, pll_power_o;
  logic [1:0]  pll_ref_sel_o, converter_clock_source_o;
  logic [3:0]  pll_p_div_o, pll_r_mult_o;
  logic        pll_r_valid_o, pll_j_valid_o;
  logic [5:0]  pll_j_o;
  logic [23:0] sixth_biquad_d1_o, sixth_biquad_d2_o;
  int          errors = 0;
  int          checked = 0;
  wire  [4:0]  mux_w = {pll_range_o, pll_ref_sel_o, converter_clock_source_o};
  wire  [9:0]  pll_w = {pll_power_o, pll_p_div_o, pll_r_mult_o, pll_r_valid_o};
  wire  [6:0]  j_w   = {pll_j_o, pll_j_valid_o};

  always #4 sys_clk_i = ~sys_clk_i;

  prc_regfile u_prc_regfile (.sys_clk_i, .reset_n_i, .host_start_i, .host_addr_i,
    .host_wr_i, .host_wdata_i, .host_rd_i, .device_status_i, .host_rdata_o,
    .host_rvalid_o, .active_page_o, .soft_reset_o, .pll_range_o, .pll_ref_sel_o,
    .converter_clock_source_o, .pll_power_o, .pll_p_div_o, .pll_r_mult_o,
    .pll_r_valid_o, .pll_j_o, .pll_j_valid_o, .sixth_biquad_d1_o, .sixth_biquad_d2_o);

  prc_host_model u_prc_host_model (.sys_clk_i(sys_clk_i), .host_rdata_i(host_rdata_o),
    .host_rvalid_i(host_rvalid_o), .host_start_o(host_start_i), .host_addr_o(host_addr_i),
    .host_wr_o(host_wr_i), .host_wdata_o(host_wdata_i), .host_rd_o(host_rd_i));

  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input logic [6:0] a, input logic [7:0] d);
    u_prc_host_model.wr(a, d);
  endtask
  task automatic r(input string n, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       v;
    u_prc_host_model.rd(a, q, v);
    chk({n, " valid"}, 24'h1, {23'h0, v});
    chk(n, {16'h0, e}, {16'h0, q});
  endtask

  task automatic t_reset();
    chk("page", 24'h0, {16'h0, active_page_o});
    chk("mux", 24'h0, {19'h0, mux_w});
    chk("pll", {14'h0, 1'b0, 4'h1, 4'h1, 1'b1}, {14'h0, pll_w});
    r("reg3", 7'h03, 8'h00);
    r("reg5", 7'h05, 8'h11);
  endtask
  task automatic t_mux();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, i[2], 2'b00, i[1:0], ~i[1:0]};
      w(7'h04, v);
      chk("mux", {19'h0, v[6], v[3:2], v[1:0]}, {19'h0, mux_w});
      r("reg4", 7'h04, v);
    end
    w(7'h04, 8'h4f);
    r("reg4 rsvd", 7'h04, 8'h4f);
  endtask
  task automatic t_pll();
    logic [7:0] v;
    logic [3:0] pe;
    logic       re;
    for (int i = 0; i < 16; i++) begin
      v = {i[0], i[2:0], i[3:0]};
      pe = (v[6:4] == 3'h0) ? 4'h8 : {1'b0, v[6:4]};
      re = (v[3:0] >= 4'h1) && (v[3:0] <= 4'h4);
      w(7'h05, v);
      chk("pll", {14'h0, v[7], pe, v[3:0], re}, {14'h0, pll_w});
      r("reg5", 7'h05, v);
    end
  endtask
  task automatic t_jval();
    logic [7:0] x;
    for (int i = 0; i < 4; i++) begin
      x = 8'(32'h03043f05 >> (24 - 8 * i));
      w(7'h06, x);
      chk("j", {17'h0, x[5:0], x[5:0] >= 6'h04}, {17'h0, j_w});
      r("reg6", 7'h06, {2'b00, x[5:0]});
    end
  endtask
  task automatic t_page();
    logic [71:0] tp;
    logic [8:0]  ok;
    tp = 72'h01_2c_34_35_3d_3e_46_47_ff;
    ok = 9'h1cc;
    for (int i = 0; i < 9; i++) begin
      w(7'h00, tp[71 - 8 * i -: 8]);
      chk("page", {16'h0, tp[71 - 8 * i -: 8]}, {16'h0, active_page_o});
      r("sel", 7'h00, tp[71 - 8 * i -: 8]);
      w(7'h7f, 8'h5a ^ tp[71 - 8 * i -: 8]);
      r("page rw", 7'h7f, ok[8 - i] ? 8'h5a ^ tp[71 - 8 * i -: 8] : 8'h00);
    end
    w(7'h05, 8'h00);
    w(7'h00, 8'h00);
    r("reg5 kept", 7'h05, 8'hff);
  endtask
  task automatic t_coef();
    logic [23:0] q;
    logic        v;
    w(7'h00, 8'h2c);
    u_prc_host_model.wr3(7'h7c, 24'h60b305);
    chk("d1", 24'h60b305, sixth_biquad_d1_o);
    u_prc_host_model.rd3(7'h7c, q, v);
    chk("d1 back", 24'h60b305, q);
    chk("d1 valid", 24'h1, {23'h0, v});
    w(7'h00, 8'h2d);
    u_prc_host_model.wr3(7'h08, 24'h807484);
    chk("d2", 24'h807484, sixth_biquad_d2_o);
    chk("d1 kept", 24'h60b305, sixth_biquad_d1_o);
    w(7'h00, 8'h00);
  endtask
  task automatic t_srst();
    w(7'h04, 8'h4f);
    w(7'h01, 8'h00);
    chk("mux held", 24'h1f, {19'h0, mux_w});
    u_prc_host_model.step(1'b1, 7'h01, 1'b1, 8'h01, 1'b0);
    chk("srst", 24'h1, {23'h0, soft_reset_o});
    u_prc_host_model.idle();
    chk("srst end", 24'h0, {23'h0, soft_reset_o});
    chk("mux rst", 24'h0, {19'h0, mux_w});
    r("reg1", 7'h01, 8'h00);
    r("reg2", 7'h02, 8'h55);
  endtask

  task automatic test_done();
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b1;
    t_reset();
    t_mux();
    t_pll();
    t_jval();
    t_page();
    t_coef();
    t_srst();
    test_done();
  end
  initial begin
    #(8 * 20000);
    errors++;
    test_done();
  end
endmodule // tb
